/* File: core/bk_defines.svh */
`ifndef BK_DEFINES_SVH
`define BK_DEFINES_SVH

// register addresses on the serial register port
`define BK_ADDR_ONE_MAIN 8'h10
`define BK_ADDR_ONE_SLEW 8'h11
`define BK_ADDR_ONE_STBY 8'h12
`define BK_ADDR_TWO_MAIN 8'h13
`define BK_ADDR_TWO_SLEW 8'h14
`define BK_ADDR_TWO_STBY 8'h15
`define BK_ADDR_FIRST 8'h10
`define BK_ADDR_LAST 8'h15

// field positions
`define BK_BIT_ENABLE 7
`define BK_BIT_RIPPLE 6
`define BK_BIT_PWM_ONLY 5
`define BK_BIT_STBY_REQ 6
`define BK_BIT_DISCHARGE 5
`define BK_PHASE_HI 4
`define BK_PHASE_LO 3
`define BK_CODE_HI 4
`define BK_SLEW_HI 2

// writable bit masks; unused bits are never stored and read as zero
`define BK_MASK_MAIN 8'hFF
`define BK_MASK_ONE_SLEW 8'h7F
`define BK_MASK_TWO_SLEW 8'h67
`define BK_MASK_STBY 8'h1F

// power-up values: 1.24 V, 180 deg + 15.36 mV/us, 1.80 V, 1.8 V standby
`define BK_RST_ONE_MAIN 8'h10
`define BK_RST_ONE_SLEW 8'h16
`define BK_RST_ONE_STBY 8'h00
`define BK_RST_TWO_MAIN 8'h0A
`define BK_RST_TWO_SLEW 8'h00
`define BK_RST_TWO_STBY 8'h0A

// slew settings
`define BK_SLEW_IMMEDIATE 3'h7
`define BK_CLK_MHZ 50
// one code step at the slowest rate: 40 mV at 0.24 mV/us
`define BK_SLOW_STEP_NS 166667
`define BK_SLOW_STEP_CYC ((`BK_SLOW_STEP_NS * `BK_CLK_MHZ) / 1000)

`endif

/* File: core/bk_pkg.sv */
package bk_pkg;

  typedef logic [7:0] bk_byte_t;
  typedef logic [4:0] bk_code_t;

  // gray-coded stepper states
  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_RAMP = 2'b01
  } bk_step_e;

  typedef struct packed {
    bk_step_e st;
    logic [4:0] level;
    logic [31:0] cnt;
    logic [4:0] code;
    logic busy;
  } bk_step_s;

  // bank order: 0 one_main .. 5 two_stby
  typedef struct packed {
    bk_byte_t [5:0] regs;
    bk_byte_t rdata;
    logic rd_hit;
    logic one_en;
    logic one_rpl;
    logic one_pwm;
    logic one_dis;
    logic two_en;
    logic two_rpl;
    logic two_pwm;
    logic two_dis;
    logic [1:0] phase;
  } bk_top_s;

endpackage : bk_pkg

/* File: core/bk_stepper.sv */
`timescale 1ns/1ps
`include "bk_defines.svh"

module bk_stepper #(
  parameter int STEP_BASE_CYCLES = `BK_SLOW_STEP_CYC,
  parameter logic [4:0] RESET_CODE = 5'h00
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire bk_pkg::bk_code_t target_code,
  input wire logic [2:0] slew_code,
  output logic [4:0] present_code,
  output logic busy
);

  // refuse bases that collapse to less than two cycles at the fastest rate
  if (STEP_BASE_CYCLES < 128) begin : g_chk
    $error("bk_stepper: STEP_BASE_CYCLES too small");
  end

  // code 31 is the lowest level, so ramps run on a level index
  function automatic logic [4:0] code_to_level(input logic [4:0] c);
    code_to_level = c + 5'h01;
  endfunction : code_to_level

  function automatic logic [4:0] level_to_code(input logic [4:0] l);
    level_to_code = l - 5'h01;
  endfunction : level_to_code

  bk_pkg::bk_step_s s_r;
  bk_pkg::bk_step_s s_nxt;
  logic [4:0] tgt_level;
  logic [31:0] interval;

  assign tgt_level = code_to_level(target_code);
  // each faster code halves the dwell per level
  assign interval = (STEP_BASE_CYCLES >> slew_code) - 1;

  always_comb begin
    s_nxt = s_r;
    if (!enable || slew_code == `BK_SLEW_IMMEDIATE) begin
      s_nxt.level = tgt_level;
      s_nxt.cnt = '0;
      s_nxt.st = bk_pkg::BK_IDLE;
    end else if (s_r.level == tgt_level) begin
      s_nxt.cnt = '0;
      s_nxt.st = bk_pkg::BK_IDLE;
    end else begin
      s_nxt.st = bk_pkg::BK_RAMP;
      if (s_r.cnt >= interval) begin
        s_nxt.cnt = '0;
        s_nxt.level = (s_r.level < tgt_level) ? s_r.level + 5'h01 : s_r.level - 5'h01;
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
      end
    end
    // registered copies keep the outputs straight off flops
    s_nxt.code = level_to_code(s_nxt.level);
    s_nxt.busy = (s_nxt.st == bk_pkg::BK_RAMP);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r.st <= bk_pkg::BK_IDLE;
      s_r.level <= code_to_level(RESET_CODE);
      s_r.cnt <= '0;
      s_r.code <= RESET_CODE;
      s_r.busy <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign present_code = s_r.code;
  assign busy = s_r.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_slow_enabled;
    enable && slew_code != `BK_SLEW_IMMEDIATE;
  endsequence

  a_step_immediate: assert property (
    enable && slew_code == `BK_SLEW_IMMEDIATE |=> s_r.level == code_to_level($past(target_code)))
    else $error("immediate slew did not jump to target");

  a_step_single: assert property (
    s_slow_enabled ##1 s_slow_enabled |->
      (s_r.level - $past(s_r.level) == 5'h01) || ($past(s_r.level) - s_r.level == 5'h01)
      || $stable(s_r.level))
    else $error("ramp moved more than one level");

  a_step_dwell: assert property (
    s_slow_enabled ##0 $changed(s_r.level) |=> s_slow_enabled |-> $stable(s_r.level))
    else $error("ramp stepped twice in consecutive cycles");

endmodule : bk_stepper

/* File: core/bk_buck_regs.sv */
`timescale 1ns/1ps
`include "bk_defines.svh"

module bk_buck_regs #(
  parameter int STEP_BASE_CYCLES = `BK_SLOW_STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic buck_one_enable,
  output logic buck_one_ripple_select,
  output logic buck_one_pwm_only,
  output logic buck_one_discharge_enable,
  output logic [4:0] buck_one_voltage_code,
  output logic buck_one_busy,
  output logic buck_two_enable,
  output logic buck_two_ripple_select,
  output logic buck_two_pwm_only,
  output logic buck_two_discharge_enable,
  output logic [4:0] buck_two_voltage_code,
  output logic buck_two_busy,
  output logic [1:0] buck_phase_delay
);

  if (STEP_BASE_CYCLES < 128) begin : g_chk
    $error("bk_buck_regs: STEP_BASE_CYCLES too small");
  end

  bk_pkg::bk_top_s s_r;
  bk_pkg::bk_top_s s_nxt;

  // address to bank slot; slot 7 marks an unmapped address
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    if (a >= `BK_ADDR_FIRST && a <= `BK_ADDR_LAST) begin
      slot_of = a[2:0] - 3'h0;
    end else begin
      slot_of = 3'h7;
    end
  endfunction : slot_of

  function automatic logic [7:0] mask_of(input logic [2:0] slot);
    case (slot)
      3'h0: mask_of = `BK_MASK_MAIN;
      3'h1: mask_of = `BK_MASK_ONE_SLEW;
      3'h2: mask_of = `BK_MASK_STBY;
      3'h3: mask_of = `BK_MASK_MAIN;
      3'h4: mask_of = `BK_MASK_TWO_SLEW;
      3'h5: mask_of = `BK_MASK_STBY;
      default: mask_of = 8'h00;
    endcase
  endfunction : mask_of

  logic [2:0] wslot;
  logic [7:0] cur;
  logic [7:0] wmask;
  logic one_stby;
  logic two_stby;

  // 0x10 maps to slot 0 since only the low three bits differ in range
  assign wslot = (slot_of(reg_addr) == 3'h7) ? 3'h7 : reg_addr[2:0] - 3'h0 - 3'h0;
  assign wmask = mask_of(wslot);
  assign cur = (wslot == 3'h7) ? 8'h00 : s_r.regs[wslot];
  assign one_stby = s_r.regs[1][`BK_BIT_STBY_REQ];
  assign two_stby = s_r.regs[4][`BK_BIT_STBY_REQ];

  always_comb begin
    s_nxt = s_r;
    if (reg_wr_en && wslot != 3'h7) begin
      s_nxt.regs[wslot] = (cur & ~wmask) | (reg_wdata & wmask);
    end
    // read answer, zero and no hit when unmapped
    if (reg_rd_en) begin
      s_nxt.rdata = cur;
      s_nxt.rd_hit = (wslot != 3'h7);
    end
    s_nxt.one_en = s_r.regs[0][`BK_BIT_ENABLE];
    s_nxt.one_rpl = s_r.regs[0][`BK_BIT_RIPPLE];
    s_nxt.two_en = s_r.regs[3][`BK_BIT_ENABLE];
    s_nxt.two_rpl = s_r.regs[3][`BK_BIT_RIPPLE];
    s_nxt.one_pwm = s_r.regs[0][`BK_BIT_PWM_ONLY] && !one_stby;
    s_nxt.two_pwm = s_r.regs[3][`BK_BIT_PWM_ONLY] && !two_stby;
    s_nxt.one_dis = s_r.regs[1][`BK_BIT_DISCHARGE];
    s_nxt.two_dis = s_r.regs[4][`BK_BIT_DISCHARGE];
    s_nxt.phase = s_r.regs[1][`BK_PHASE_HI:`BK_PHASE_LO];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r.regs[0] <= `BK_RST_ONE_MAIN;
      s_r.regs[1] <= `BK_RST_ONE_SLEW;
      s_r.regs[2] <= `BK_RST_ONE_STBY;
      s_r.regs[3] <= `BK_RST_TWO_MAIN;
      s_r.regs[4] <= `BK_RST_TWO_SLEW;
      s_r.regs[5] <= `BK_RST_TWO_STBY;
      s_r.rdata <= 8'h00;
      s_r.rd_hit <= 1'b0;
      s_r.one_en <= 1'b0;
      s_r.one_rpl <= 1'b0;
      s_r.one_pwm <= 1'b0;
      s_r.one_dis <= 1'b0;
      s_r.two_en <= 1'b0;
      s_r.two_rpl <= 1'b0;
      s_r.two_pwm <= 1'b0;
      s_r.two_dis <= 1'b0;
      s_r.phase <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // standby picks the standby level as target
  bk_pkg::bk_code_t one_target;
  bk_pkg::bk_code_t two_target;
  assign one_target = one_stby ? s_r.regs[2][`BK_CODE_HI:0] : s_r.regs[0][`BK_CODE_HI:0];
  assign two_target = two_stby ? s_r.regs[5][`BK_CODE_HI:0] : s_r.regs[3][`BK_CODE_HI:0];

  // per-converter ramps; buck two moves twice the voltage per level
  bk_stepper #(
    .STEP_BASE_CYCLES(STEP_BASE_CYCLES),
    .RESET_CODE(5'h10)
  ) u_one_ramp (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(s_r.regs[0][`BK_BIT_ENABLE]),
    .target_code(one_target),
    .slew_code(s_r.regs[1][`BK_SLEW_HI:0]),
    .present_code(buck_one_voltage_code),
    .busy(buck_one_busy)
  );

  bk_stepper #(
    .STEP_BASE_CYCLES(STEP_BASE_CYCLES),
    .RESET_CODE(5'h0A)
  ) u_two_ramp (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(s_r.regs[3][`BK_BIT_ENABLE]),
    .target_code(two_target),
    .slew_code(s_r.regs[4][`BK_SLEW_HI:0]),
    .present_code(buck_two_voltage_code),
    .busy(buck_two_busy)
  );

  // outputs straight from flops
  assign reg_rdata = s_r.rdata;
  assign reg_hit = s_r.rd_hit;
  assign buck_one_enable = s_r.one_en;
  assign buck_one_ripple_select = s_r.one_rpl;
  assign buck_one_pwm_only = s_r.one_pwm;
  assign buck_one_discharge_enable = s_r.one_dis;
  assign buck_two_enable = s_r.two_en;
  assign buck_two_ripple_select = s_r.two_rpl;
  assign buck_two_pwm_only = s_r.two_pwm;
  assign buck_two_discharge_enable = s_r.two_dis;
  assign buck_phase_delay = s_r.phase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rd(logic [7:0] a);
    reg_rd_en && !reg_wr_en && reg_addr == a;
  endsequence

  a_write_main: assert property (
    reg_wr_en && reg_addr == `BK_ADDR_ONE_MAIN |=> s_r.regs[0] == $past(reg_wdata))
    else $error("main register write not stored");

  a_stby_readonly: assert property (
    reg_wr_en && reg_addr == `BK_ADDR_ONE_STBY |=>
      s_r.regs[2] == {3'b000, $past(reg_wdata[4:0])})
    else $error("standby register high bits not read-only");

  a_read_back: assert property (
    s_rd(`BK_ADDR_TWO_STBY) |=> reg_hit && reg_rdata == s_r.regs[5])
    else $error("read of 0x15 returned wrong data");

  a_unmapped_zero: assert property (
    reg_rd_en && (reg_addr < `BK_ADDR_FIRST || reg_addr > `BK_ADDR_LAST) |=>
      !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_unused_zero: assert property (
    s_rd(`BK_ADDR_ONE_SLEW) |=> reg_rdata[7] == 1'b0)
    else $error("unused bit read as one");

  a_reset_vals: assert property (
    $fell(sys_rst) |-> s_r.regs[0] == `BK_RST_ONE_MAIN && s_r.regs[1] == `BK_RST_ONE_SLEW
      && s_r.regs[3] == `BK_RST_TWO_MAIN && s_r.regs[5] == `BK_RST_TWO_STBY)
    else $error("power-up defaults wrong");

  a_standby_pfm: assert property (
    one_stby |=> !buck_one_pwm_only)
    else $error("standby did not force pfm");

  // written phase field reaches the output one cycle after the write edge
  a_phase_out: assert property (
    reg_wr_en && reg_addr == `BK_ADDR_ONE_SLEW |=>
      ##1 buck_phase_delay == $past(reg_wdata[`BK_PHASE_HI:`BK_PHASE_LO], 2))
    else $error("phase output does not follow written field");

  a_disch_out: assert property (
    reg_wr_en && reg_addr == `BK_ADDR_TWO_SLEW |=>
      ##1 buck_two_discharge_enable == $past(reg_wdata[`BK_BIT_DISCHARGE], 2))
    else $error("discharge output does not follow written field");

endmodule : bk_buck_regs

/* File: bench/bk_host_model.sv */
`timescale 1ns/1ps
// host side of the register port; gap adds idle cycles like a slow serial engine
module bk_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  int gap = 0;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end

  // released lines are inverted so a stale address never looks like a live one
  task automatic drop(input logic wr);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~reg_addr;
    if (wr) begin
      reg_wdata <= ~reg_wdata;
    end
  endtask : drop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    drop(1'b1);
    repeat (gap) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    drop(1'b0);
    @(negedge clk);
    d = reg_rdata;
    h = reg_hit;
    repeat (gap) @(posedge clk);
  endtask : rd
endmodule : bk_host_model

/* File: bench/tb_bk_buck_regs.sv */
`timescale 1ns/1ps
module tb_bk_buck_regs;
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr_en, reg_rd_en, reg_hit, rh;
  logic e1, r1, p1, d1, b1, e2, r2, p2, d2, b2;
  logic [4:0] v1, v2;
  logic [1:0] ph;
  logic [7:0] f1, f2;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] rst_tab [6] = '{8'h10, 8'h16, 8'h00, 8'h0A, 8'h00, 8'h0A};
  logic [7:0] msk_tab [6] = '{8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'h67, 8'h1F};

  // flags packed as enable, ripple, pwm_only, discharge
  assign f1 = {4'h0, e1, r1, p1, d1};
  assign f2 = {4'h0, e2, r2, p2, d2};

  bk_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  // small step base keeps each test ramp within a few hundred cycles
  bk_buck_regs #(.STEP_BASE_CYCLES(128)) DUT (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .buck_one_enable(e1), .buck_one_ripple_select(r1), .buck_one_pwm_only(p1),
    .buck_one_discharge_enable(d1), .buck_one_voltage_code(v1), .buck_one_busy(b1),
    .buck_two_enable(e2), .buck_two_ripple_select(r2), .buck_two_pwm_only(p2),
    .buck_two_discharge_enable(d2), .buck_two_voltage_code(v2), .buck_two_busy(b2),
    .buck_phase_delay(ph));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    host.rd(a, rv, rh);
    chk("reg_rdata", rv, e);
    chk("reg_hit", {7'h00, rh}, {7'h00, eh});
  endtask : rdchk

  task automatic outs(input logic [7:0] ef1, input logic [4:0] ev1,
                      input logic [7:0] ef2, input logic [4:0] ev2);
    chk("buck_one flags", f1, ef1);
    chk("buck_one_voltage_code", {3'h0, v1}, {3'h0, ev1});
    chk("buck_two flags", f2, ef2);
    chk("buck_two_voltage_code", {3'h0, v2}, {3'h0, ev2});
  endtask : outs

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // watchdog well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle(2);
    // power-up values
    outs(8'h00, 5'h10, 8'h00, 5'h0A);
    chk("buck_phase_delay", {6'h00, ph}, 8'h02);
    chk("buck_one_busy", {7'h00, b1}, 8'h00);
    chk("buck_two_busy", {7'h00, b2}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdchk(8'h10 + 8'(i), rst_tab[i], 1'b1);
    end
    $display("test reset_values done");
    // writable masks
    for (int i = 0; i < 6; i++) begin
      host.wr(8'h10 + 8'(i), 8'hFF);
      rdchk(8'h10 + 8'(i), msk_tab[i], 1'b1);
    end
    host.wr(8'h0F, 8'h00);
    host.wr(8'h16, 8'h00);
    rdchk(8'h10, 8'hFF, 1'b1);
    rdchk(8'h16, 8'h00, 1'b0);
    rdchk(8'h0F, 8'h00, 1'b0);
    $display("test access_masks done");
    // standby forces pfm and level; slow host spacing here
    host.gap = 2;
    settle(3);
    outs(8'h0D, 5'h1F, 8'h0D, 5'h1F);
    host.wr(8'h12, 8'h05);
    host.wr(8'h15, 8'h09);
    settle(3);
    outs(8'h0D, 5'h05, 8'h0D, 5'h09);
    host.wr(8'h11, 8'h3F);
    host.wr(8'h14, 8'h27);
    settle(3);
    outs(8'h0F, 5'h1F, 8'h0F, 5'h1F);
    host.gap = 0;
    $display("test standby done");
    // phase field
    for (int p = 0; p < 4; p++) begin
      host.wr(8'h11, {3'b001, 2'(p), 3'b111});
      settle(3);
      chk("buck_phase_delay", {6'h00, ph}, 8'(p));
    end
    // main register fields
    for (int b = 5; b < 8; b++) begin
      host.wr(8'h10, (8'h01 << b) | 8'h0A);
      host.wr(8'h13, (8'h01 << b) | 8'h06);
      settle(3);
      outs((8'h01 << (b - 4)) | 8'h01, 5'h0A, (8'h01 << (b - 4)) | 8'h01, 5'h06);
    end
    $display("test fields done");
    // ramp at slowest rate, one step per 128 cycles
    host.wr(8'h11, 8'h20);
    host.wr(8'h10, 8'h8C);
    settle(100);
    chk("buck_one_voltage_code", {3'h0, v1}, 8'h0A);
    chk("buck_one_busy", {7'h00, b1}, 8'h01);
    settle(100);
    chk("buck_one_voltage_code", {3'h0, v1}, 8'h0B);
    settle(200);
    chk("buck_one_voltage_code", {3'h0, v1}, 8'h0C);
    chk("buck_one_busy", {7'h00, b1}, 8'h00);
    // code 011 is eight times faster: one step per 16 cycles
    host.wr(8'h11, 8'h23);
    host.wr(8'h10, 8'h8A);
    settle(20);
    chk("buck_one_voltage_code", {3'h0, v1}, 8'h0B);
    chk("buck_one_busy", {7'h00, b1}, 8'h01);
    settle(40);
    chk("buck_one_voltage_code", {3'h0, v1}, 8'h0A);
    chk("buck_one_busy", {7'h00, b1}, 8'h00);
    // buck two one level up at its slowest rate
    host.wr(8'h14, 8'h20);
    host.wr(8'h13, 8'h87);
    settle(60);
    chk("buck_two_voltage_code", {3'h0, v2}, 8'h06);
    chk("buck_two_busy", {7'h00, b2}, 8'h01);
    settle(100);
    chk("buck_two_voltage_code", {3'h0, v2}, 8'h07);
    chk("buck_two_busy", {7'h00, b2}, 8'h00);
    $display("test ramp done");
    // mid-run reset restores the power-up state
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle(2);
    outs(8'h00, 5'h10, 8'h00, 5'h0A);
    chk("buck_phase_delay", {6'h00, ph}, 8'h02);
    chk("buck_two_busy", {7'h00, b2}, 8'h00);
    rdchk(8'h11, 8'h16, 1'b1);
    rdchk(8'h15, 8'h0A, 1'b1);
    $display("test mid_reset done");
    summarize();
  end
endmodule : tb_bk_buck_regs
